// >>> rtl/ebp_top.sv
// ebp_top: bootstrap programming sequencer with its control registers on AXI4-Lite
// Assumes an external 12-bit counter feeding a source memory onto SOURCE_DATA
`include "ebp_map.svh"
`default_nettype none
module ebp_top #(
	parameter int unsigned PULSE_CYCLES = `EBP_PULSE_CYC
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CLK_EN,
	input wire logic TIMER_PIN_HIGH_VOLTAGE,
	input wire logic VPP_HIGH,
	input wire ebp_pkg::ebp_byte_t SOURCE_DATA,
	output logic COUNTER_CLEAR_OUT,
	output logic COUNTER_STEP_OUT,
	output logic PROGRAMMED_LED,
	output logic VERIFIED_LED,
	output logic BOOT_MODE,
	output var ebp_pkg::ebp_addr_t START_VECTOR,
	input wire logic [15:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [15:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	import ebp_pkg::*;
	localparam logic [23:0] EDGE_CNT = 24'(`EBP_EDGE_CYC);
	localparam logic [23:0] PULSE_CNT = 24'(PULSE_CYCLES);

	function automatic logic is_eprom(ebp_addr_t a);
		// Boot ROM and vectors sit above the option byte, so the boot walk never writes them
		return (a >= `EBP_XROM_LO) && (a <= `EBP_OPT_IDX);
	endfunction : is_eprom

	function automatic logic is_ram(ebp_addr_t a);
		return (a >= `EBP_RAM_IDX_LO) && (a <= `EBP_RAM_IDX_HI);
	endfunction : is_ram

	function automatic logic reg_hit(ebp_addr_t a, logic wr);
		logic both;
		both = (a == `EBP_PCR_IDX) || (a == `EBP_LADDR_LO_IDX) || (a == `EBP_LADDR_HI_IDX)
			|| (a == `EBP_LDATA_IDX) || is_ram(a);
		if (wr) begin
			return both || (a == `EBP_ERASE_IDX);
		end
		return both || (a == `EBP_STATUS_IDX) || (a == `EBP_WINDOW_IDX) || (a == `EBP_OPT_IDX);
	endfunction : reg_hit

	// Pin synchronisers, not reset so pins are already settled at release
	logic [9:0] pin_meta;
	logic [9:0] pin_sync;
	always_ff @(posedge CLOCK) begin
		if (CLK_EN) begin
			pin_meta <= {TIMER_PIN_HIGH_VOLTAGE, VPP_HIGH, SOURCE_DATA};
			pin_sync <= pin_meta;
		end
	end
	logic timer_hv;
	logic high_voltage_absent;
	ebp_byte_t src;
	assign timer_hv = pin_sync[9];
	assign high_voltage_absent = ~pin_sync[8];
	assign src = pin_sync[7:0];

	// Mode caught at the first enabled edge after reset release; no supply monitor here
	logic rst_q;
	logic boot;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rst_q <= 1'h1;
			boot <= 1'h0;
			START_VECTOR <= `EBP_RESET_VEC;
		end else if (CLK_EN) begin
			rst_q <= 1'h0;
			if (rst_q) begin
				boot <= timer_hv;
				START_VECTOR <= timer_hv ? `EBP_BOOT_VEC : `EBP_RESET_VEC;
			end
		end
	end
	assign BOOT_MODE = boot;

	// Bus slave and decode
	logic wr_en;
	ebp_addr_t w_idx;
	ebp_byte_t w_dat;
	ebp_addr_t r_idx;
	ebp_byte_t rd_val;
	ebp_axil u_axil (
		.clk(CLOCK),
		.rst(RESET),
		.ce(CLK_EN),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.wr_en(wr_en),
		.wr_idx(w_idx),
		.wr_data(w_dat),
		.wr_hit(reg_hit(w_idx, 1'h1)),
		.rd_idx(r_idx),
		.rd_data(rd_val),
		.rd_hit(reg_hit(r_idx, 1'h0))
	);

	// Sequencer state
	ebp_state_t state;
	ebp_state_t next_state;
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	ebp_addr_t addr;
	ebp_addr_t next_addr;
	logic pass;
	logic next_pass;
	logic mismatch;
	logic next_mismatch;
	logic programmed;
	logic next_programmed;
	logic verified;
	logic next_verified;
	logic cnt_end;
	ebp_byte_t arr_rd;
	assign cnt_end = (cnt == 24'h0);

	always_comb begin
		next_state = state;
		next_cnt = cnt_end ? cnt : cnt - 24'h1;
		next_addr = addr;
		next_pass = pass;
		next_mismatch = mismatch;
		next_programmed = programmed;
		next_verified = verified;
		case (state)
			S_IDLE: begin
				if (boot) begin
					next_state = S_CLR_HI;
					next_cnt = EDGE_CNT - 24'h1;
				end
			end
			S_CLR_HI: begin
				if (cnt_end) begin
					next_state = S_CLR_LO;
					next_cnt = EDGE_CNT - 24'h1;
				end
			end
			S_CLR_LO: begin
				if (cnt_end) begin
					next_state = S_SETTLE;
					next_cnt = EDGE_CNT - 24'h1;
					next_addr = 12'h000;
				end
			end
			S_SETTLE: begin
				if (cnt_end) begin
					if (!is_eprom(addr)) begin
						next_state = S_STEP_HI;
						next_cnt = EDGE_CNT - 24'h1;
					end else if (pass) begin
						next_mismatch = mismatch | (arr_rd != src);
						next_state = S_STEP_HI;
						next_cnt = EDGE_CNT - 24'h1;
					end else begin
						next_state = S_LATCH;
					end
				end
			end
			S_LATCH: begin
				next_state = S_PULSE;
				next_cnt = PULSE_CNT - 24'h1;
			end
			S_PULSE: begin
				if (cnt_end) begin
					next_state = S_RELEASE;
				end
			end
			S_RELEASE: begin
				next_state = S_STEP_HI;
				next_cnt = EDGE_CNT - 24'h1;
			end
			S_STEP_HI: begin
				if (cnt_end) begin
					next_state = S_STEP_LO;
					next_cnt = EDGE_CNT - 24'h1;
				end
			end
			S_STEP_LO: begin
				if (cnt_end) begin
					next_cnt = EDGE_CNT - 24'h1;
					if (addr != `EBP_LAST_ADDR) begin
						next_addr = addr + 12'h001;
						next_state = S_SETTLE;
					end else if (!pass) begin
						next_programmed = 1'h1;
						next_pass = 1'h1;
						next_state = S_CLR_HI;
					end else begin
						next_verified = ~mismatch;
						next_state = S_DONE;
					end
				end
			end
			S_DONE: next_state = S_DONE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state <= S_IDLE;
			cnt <= 24'h0;
			addr <= 12'h000;
			pass <= 1'h0;
			mismatch <= 1'h0;
			programmed <= 1'h0;
			verified <= 1'h0;
			COUNTER_CLEAR_OUT <= 1'h0;
			COUNTER_STEP_OUT <= 1'h0;
		end else if (CLK_EN) begin
			state <= next_state;
			cnt <= next_cnt;
			addr <= next_addr;
			pass <= next_pass;
			mismatch <= next_mismatch;
			programmed <= next_programmed;
			verified <= next_verified;
			COUNTER_CLEAR_OUT <= (state == S_CLR_HI);
			COUNTER_STEP_OUT <= (state == S_STEP_HI);
		end
	end
	assign PROGRAMMED_LED = programmed;
	assign VERIFIED_LED = verified;

	// Programming control register; the sequencer owns it in boot mode
	logic ple_n;
	logic pge_n;
	logic next_ple_n;
	logic next_pge_n;
	logic seq_ple_n;
	logic seq_pge_n;
	logic sw_pcr_wr;
	assign seq_ple_n = ~((state == S_LATCH) || (state == S_PULSE));
	assign seq_pge_n = ~(state == S_PULSE);
	assign sw_pcr_wr = wr_en & (w_idx == `EBP_PCR_IDX) & ~boot;
	assign next_ple_n = boot ? seq_ple_n : (sw_pcr_wr ? w_dat[`EBP_PCR_PLE] : ple_n);
	assign next_pge_n = boot ? seq_pge_n : (sw_pcr_wr ?
		(w_dat[`EBP_PCR_PGE] | w_dat[`EBP_PCR_PLE]) : pge_n);

	// Software latch registers, erase command and working RAM
	ebp_addr_t sw_laddr;
	ebp_byte_t sw_ldata;
	logic erase;
	ebp_byte_t ram [0:`EBP_RAM_WORDS-1];
	logic [5:0] w_ram;
	logic [5:0] r_ram;
	assign w_ram = 6'(w_idx - `EBP_RAM_IDX_LO);
	assign r_ram = 6'(r_idx - `EBP_RAM_IDX_LO);
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ple_n <= 1'h1;
			pge_n <= 1'h1;
			sw_laddr <= 12'h000;
			sw_ldata <= 8'h00;
			erase <= 1'h0;
		end else if (CLK_EN) begin
			ple_n <= next_ple_n;
			pge_n <= next_pge_n;
			erase <= wr_en & (w_idx == `EBP_ERASE_IDX) & w_dat[0];
			if (wr_en && (w_idx == `EBP_LADDR_LO_IDX)) sw_laddr[7:0] <= w_dat;
			if (wr_en && (w_idx == `EBP_LADDR_HI_IDX)) sw_laddr[11:8] <= w_dat[3:0];
			if (wr_en && (w_idx == `EBP_LDATA_IDX)) sw_ldata <= w_dat;
		end
	end
	always_ff @(posedge CLOCK) begin
		if (CLK_EN && wr_en && is_ram(w_idx)) begin
			ram[w_ram] <= w_dat;
		end
	end

	// Address and data latch into the array; both bits are dead without high voltage
	ebp_addr_t lat_addr;
	ebp_byte_t lat_data;
	logic latch;
	logic prog;
	assign latch = ~high_voltage_absent & ~ple_n & pge_n;
	assign prog = ~high_voltage_absent & ~ple_n & ~pge_n;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			lat_addr <= 12'h000;
			lat_data <= 8'h00;
		end else if (CLK_EN && latch) begin
			lat_addr <= boot ? addr : sw_laddr;
			lat_data <= boot ? src : sw_ldata;
		end
	end

	ebp_byte_t win_data;
	ebp_byte_t opt_data;
	logic secure;
	ebp_eprom_array u_array (
		.clk(CLOCK),
		.rst(RESET),
		.ce(CLK_EN),
		.erase(erase),
		.prog(prog),
		.prog_addr(lat_addr),
		.prog_data(lat_data),
		.rd_addr(addr),
		.rd_data(arr_rd),
		.ext_addr(sw_laddr),
		.ext_data(win_data),
		.opt_data(opt_data),
		.secure(secure)
	);

	// Read selection
	ebp_byte_t pcr_val;
	ebp_byte_t status_val;
	logic busy;
	assign busy = (state != S_IDLE) && (state != S_DONE);
	assign pcr_val = {`EBP_PCR_ONES, high_voltage_absent, pge_n, ple_n};
	assign status_val = {2'h0, secure, mismatch, verified, programmed, busy, boot};
	assign rd_val = (r_idx == `EBP_PCR_IDX) ? pcr_val :
		(r_idx == `EBP_STATUS_IDX) ? status_val :
		(r_idx == `EBP_LADDR_LO_IDX) ? sw_laddr[7:0] :
		(r_idx == `EBP_LADDR_HI_IDX) ? {4'h0, sw_laddr[11:8]} :
		(r_idx == `EBP_LDATA_IDX) ? sw_ldata :
		(r_idx == `EBP_WINDOW_IDX) ? win_data :
		(r_idx == `EBP_OPT_IDX) ? opt_data :
		is_ram(r_idx) ? ram[r_ram] : 8'h00;

	// Checks
	logic [23:0] pulse_len;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pulse_len <= 24'h0;
		end else if (CLK_EN) begin
			pulse_len <= pge_n ? 24'h0 : pulse_len + 24'h1;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET || !CLK_EN);
	sequence s_clear_rise;
		COUNTER_CLEAR_OUT && !COUNTER_STEP_OUT;
	endsequence
	sequence s_quiet_step;
		!COUNTER_STEP_OUT [*8];
	endsequence
	a_boot_vector_pick: assert property ($rose(boot) |-> START_VECTOR == `EBP_BOOT_VEC)
		else $error("boot entry without boot vector");
	a_clear_on_entry: assert property (state == S_IDLE && boot |=> ##1 s_clear_rise)
		else $error("clear pulse missing at entry");
	a_step_after_clear: assert property ($fell(COUNTER_CLEAR_OUT) |-> s_quiet_step)
		else $error("step too soon after clear");
	a_step_width: assert property ($rose(COUNTER_STEP_OUT) |-> COUNTER_STEP_OUT [*8])
		else $error("step pulse too short");
	a_step_after_load: assert property ($rose(COUNTER_STEP_OUT) && !pass && is_eprom(addr)
		&& !high_voltage_absent |-> lat_addr == addr && (arr_rd & lat_data) == lat_data)
		else $error("step before location loaded");
	a_pulse_length: assert property ($rose(pge_n) && boot |-> pulse_len == PULSE_CNT)
		else $error("program pulse length wrong");
	a_pge_with_ple: assert property (!pge_n |-> !ple_n)
		else $error("program enable low with latch enable high");
	a_skip_foreign: assert property (boot && prog |-> is_eprom(lat_addr))
		else $error("write outside EPROM");
	a_programmed_end: assert property ($rose(programmed) |->
		$past(addr) == `EBP_LAST_ADDR && pass)
		else $error("programmed indicator early");
	a_verified_clean: assert property ($rose(verified) |->
		!mismatch && $past(state) == S_STEP_LO)
		else $error("verified despite mismatch");
	a_pcr_upper_ones: assert property ($past(ARVALID && ARREADY && r_idx == `EBP_PCR_IDX)
		|-> RDATA[7:3] == `EBP_PCR_ONES && RDATA[2] == $past(high_voltage_absent))
		else $error("control register readback wrong");
endmodule : ebp_top
`default_nettype wire

// >>> rtl/ebp_map.svh
// ebp_map.svh: register indices, field positions, reset values and timing counts
// Assumes inclusion by bare name from the bootstrap programmer sources
// Operation
// - Timer pin at high voltage during reset release selects the boot vector pair.
// - The bootstrap routine lives in a fixed 120-byte ROM region, not in EPROM.
// - On entry, pulse the counter clear output high then low before any byte.
// - After clearing, step the 12-bit external counter once per byte location.
// - Issue the next step pulse only after the current location is loaded.
// - Light the programmed indicator once every location has been programmed.
// - Clear the counter again and walk all addresses comparing instead of writing.
// - Light the verified indicator only when every compared byte matched.
// - Addresses outside the on-chip EPROM are skipped without any write.
// - Bootstrap programming and verification still work with secure option set.
// - Secure option clears only by erasing the whole EPROM array.
// - The 1728-byte expansion ROM area is EPROM and reads zero when erased.
// - The 48-byte expansion RAM area is real working RAM.
// - Reserved ROM region holds the bootstrap, software must not rely on it.
// - No low-voltage inhibit reset exists in this part.
// - Programming control register uses three low bits, upper five read one.
// - Program enable clears only with latch enable clear; both dead without high voltage.
// - Secure option set blocks external reads of EPROM contents; only the window reads zero, the option byte still reads back.
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_CLK_MHZ 100
`define EBP_EDGE_NS 1000
`define EBP_EDGE_CYC ((`EBP_EDGE_NS * `EBP_CLK_MHZ + 999) / 1000)
`define EBP_PULSE_US 1000
`define EBP_PULSE_CYC (`EBP_PULSE_US * `EBP_CLK_MHZ)
`define EBP_BOOT_VEC 12'hff6
`define EBP_RESET_VEC 12'hffe
`define EBP_BOOTROM_LO 12'hf80
`define EBP_BOOTROM_SIZE 120
`define EBP_XROM_LO 12'h080
`define EBP_XROM_SIZE 1728
`define EBP_LAST_ADDR 12'hfff
`define EBP_RAM_IDX_LO 12'h010
`define EBP_RAM_IDX_HI 12'h03f
`define EBP_RAM_WORDS 48
`define EBP_STATUS_IDX 12'h001
`define EBP_LADDR_LO_IDX 12'h002
`define EBP_LADDR_HI_IDX 12'h003
`define EBP_LDATA_IDX 12'h004
`define EBP_WINDOW_IDX 12'h005
`define EBP_ERASE_IDX 12'h006
`define EBP_PCR_IDX 12'h00b
`define EBP_PCR_PLE 0
`define EBP_PCR_PGE 1
`define EBP_PCR_ONES 5'h1f
`define EBP_OPT_IDX 12'hf38
`define EBP_OPT_SECURE 3
`define EBP_RESP_OKAY 2'h0
`define EBP_RESP_SLVERR 2'h2
`endif

// >>> rtl/ebp_pkg.sv
// ebp_pkg: shared types of the bootstrap programmer
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ebp_pkg;
	typedef logic [11:0] ebp_addr_t;
	typedef logic [7:0] ebp_byte_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CLR_HI = 4'h1,
		S_CLR_LO = 4'h2,
		S_SETTLE = 4'h3,
		S_LATCH = 4'h4,
		S_PULSE = 4'h5,
		S_RELEASE = 4'h6,
		S_STEP_HI = 4'h7,
		S_STEP_LO = 4'h8,
		S_DONE = 4'h9
	} ebp_state_t;
endpackage : ebp_pkg
`default_nettype wire

// >>> rtl/ebp_axil.sv
// ebp_axil: AXI4-Lite slave, one write and one read at a time, low byte lane
// Assumes the parent decodes word indices and answers with hit flags
`include "ebp_map.svh"
`default_nettype none
module ebp_axil (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [15:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output var ebp_pkg::ebp_addr_t wr_idx,
	output var ebp_pkg::ebp_byte_t wr_data,
	input wire logic wr_hit,
	output var ebp_pkg::ebp_addr_t rd_idx,
	input wire ebp_pkg::ebp_byte_t rd_data,
	input wire logic rd_hit
);
	import ebp_pkg::*;
	logic aw_got;
	logic w_got;
	logic w_lane;
	logic fire;
	assign awready = ce & ~aw_got & ~bvalid;
	assign wready = ce & ~w_got & ~bvalid;
	assign arready = ce & ~rvalid;
	// Write happens once both address and data are held
	assign fire = ce & aw_got & w_got & ~bvalid;
	assign wr_en = fire & w_lane & wr_hit;
	assign rd_idx = araddr[13:2];
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_got <= 1'h0;
			w_got <= 1'h0;
			w_lane <= 1'h0;
			wr_idx <= 12'h000;
			wr_data <= 8'h00;
			bvalid <= 1'h0;
			bresp <= `EBP_RESP_OKAY;
			rvalid <= 1'h0;
			rdata <= 32'h0;
			rresp <= `EBP_RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_got <= 1'h1;
				wr_idx <= awaddr[13:2];
			end
			if (wvalid && wready) begin
				w_got <= 1'h1;
				wr_data <= wdata[7:0];
				w_lane <= wstrb[0];
			end
			if (fire) begin
				aw_got <= 1'h0;
				w_got <= 1'h0;
				bvalid <= 1'h1;
				bresp <= wr_hit ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'h0;
			end
			if (arvalid && arready) begin
				rvalid <= 1'h1;
				rdata <= {24'h0, rd_data};
				rresp <= rd_hit ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'h0;
			end
		end
	end
endmodule : ebp_axil
`default_nettype wire

// >>> rtl/ebp_eprom_array.sv
// ebp_eprom_array: on-chip EPROM cells, erase to zero, programming sets ones
// Assumes the parent forms the program strobe from the control register
`include "ebp_map.svh"
`default_nettype none
module ebp_eprom_array (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic erase,
	input wire logic prog,
	input wire ebp_pkg::ebp_addr_t prog_addr,
	input wire ebp_pkg::ebp_byte_t prog_data,
	input wire ebp_pkg::ebp_addr_t rd_addr,
	output var ebp_pkg::ebp_byte_t rd_data,
	input wire ebp_pkg::ebp_addr_t ext_addr,
	output var ebp_pkg::ebp_byte_t ext_data,
	output var ebp_pkg::ebp_byte_t opt_data,
	output logic secure
);
	import ebp_pkg::*;
	ebp_byte_t mem [0:4095];
	always_ff @(posedge clk) begin
		if (ce) begin
			if (erase) begin
				for (int i = 0; i < 4096; i++) begin
					mem[i] <= 8'h00;
				end
			end else if (prog) begin
				mem[prog_addr] <= mem[prog_addr] | prog_data;
			end
		end
	end
	assign rd_data = mem[rd_addr];
	assign opt_data = mem[`EBP_OPT_IDX];
	assign secure = opt_data[`EBP_OPT_SECURE];
	assign ext_data = secure ? 8'h00 : mem[ext_addr];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);
	a_secure_only_erase: assert property ($fell(secure) |-> $past(erase))
		else $error("secure option cleared without erase");
	a_program_sets_ones: assert property (prog && !erase |=>
		(mem[$past(prog_addr)] & $past(prog_data)) == $past(prog_data))
		else $error("programmed byte lacks written ones");
endmodule : ebp_eprom_array
`default_nettype wire

// >>> verif/ebp_src_model.sv
// ebp_src_model: external 12-bit ripple counter feeding a source memory
// Assumes clear and step come from the sequencer; the counter advances on the falling step edge
`default_nettype none
module ebp_src_model import ebp_pkg::*; (
	input wire logic clear,
	input wire logic step,
	output var ebp_pkg::ebp_byte_t data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Power-up count is arbitrary until the first clear
	logic [11:0] count = 12'h5a5;
	always @(posedge clear or negedge step) begin
		if (clear) begin
			count <= 12'h000;
		end else begin
			count <= count + 12'h001;
		end
	end
	// Memory is always selected, so the byte follows the count
	assign data = count[7:0] ^ 8'h3c;
endmodule : ebp_src_model
`default_nettype wire

// >>> verif/ebp_top_tb_top.sv
// ebp_top_tb_top: register bus and bootstrap walk tests of the programmer
// Assumes the design sources and the source model are compiled first
`include "ebp_map.svh"
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module ebp_top_tb_top import ebp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned pulse = 4;
	localparam logic [11:0] programming_control_reg = `EBP_PCR_IDX;
	localparam logic [11:0] win = `EBP_WINDOW_IDX;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic timer_hv = 1'b0;
	logic vpp = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, clr, stp, led_p, led_v, boot;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata;
	logic [7:0] rd;
	logic seen;
	ebp_addr_t vec;
	ebp_byte_t src;
	int err_count = 0;
	int num_checks = 0;
	int n, lo7f, lo80;

	always #5 clock = ~clock;

	ebp_top #(.PULSE_CYCLES(pulse)) u_dut (.CLOCK(clock), .RESET(reset), .CLK_EN(1'b1),
		.TIMER_PIN_HIGH_VOLTAGE(timer_hv), .VPP_HIGH(vpp), .SOURCE_DATA(src),
		.COUNTER_CLEAR_OUT(clr), .COUNTER_STEP_OUT(stp), .PROGRAMMED_LED(led_p),
		.VERIFIED_LED(led_v), .BOOT_MODE(boot), .START_VECTOR(vec), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
		.WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready));
	ebp_src_model u_src (.clear(clr), .step(stp), .data(src));

	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a_done;
		logic w_done;
		a_done = 1'b0;
		w_done = 1'b0;
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(a_done && w_done)) begin
			@(posedge clock);
			if (!a_done && awready === 1'b1) begin
				a_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Response ready raised only once both halves are taken, and dropped again once the response is seen
		bready <= 1'b1;
		do @(posedge clock); while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask : wr

	task automatic rdreg(input logic [11:0] idx, output logic [7:0] d, output logic [1:0] r);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clock); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata[7:0];
		r = rresp;
		`CHK("rdata_upper", 24'h000000, rdata[31:8])
	endtask : rdreg

	task automatic chk_rd(input logic [11:0] idx, input logic [7:0] e);
		rdreg(idx, rd, resp);
		`CHK("rresp", 2'h0, resp)
		`CHK("rdata", e, rd)
	endtask : chk_rd

	// Software programming of one byte through the latch registers and control register
	task automatic prog_byte(input logic [11:0] a, input logic [7:0] d);
		wr(`EBP_LADDR_LO_IDX, a[7:0], 2'h0);
		wr(`EBP_LADDR_HI_IDX, {4'h0, a[11:8]}, 2'h0);
		wr(`EBP_LDATA_IDX, d, 2'h0);
		wr(programming_control_reg, 8'h02, 2'h0);
		wr(programming_control_reg, 8'h00, 2'h0);
		repeat (pulse + 4) @(posedge clock);
		wr(programming_control_reg, 8'h03, 2'h0);
	endtask : prog_byte

	task automatic do_reset(input logic tp);
		timer_hv <= tp;
		reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
	endtask : do_reset

	// Counts edges until the step output is seen high
	task automatic count_low(output int c);
		c = 0;
		while (stp !== 1'b1) begin
			@(posedge clock);
			c++;
		end
	endtask : count_low

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		tally_and_finish();
	end

	initial begin
		do_reset(1'b0);
		@(posedge clock);
		`CHK("boot_mode", 1'b0, boot)
		`CHK("vector", 12'hffe, vec)
		chk_rd(programming_control_reg, 8'hff);
		vpp <= 1'b1;
		repeat (4) @(posedge clock);
		chk_rd(programming_control_reg, 8'hfb);
		wr(programming_control_reg, 8'h00, 2'h0);
		chk_rd(programming_control_reg, 8'hf8);
		wr(programming_control_reg, 8'h01, 2'h0);
		chk_rd(programming_control_reg, 8'hfb);
		wr(`EBP_ERASE_IDX, 8'h01, 2'h0);
		chk_rd(`EBP_STATUS_IDX, 8'h00);
		chk_rd(`EBP_OPT_IDX, 8'h00);
		wr(`EBP_LADDR_LO_IDX, 8'h80, 2'h0);
		wr(`EBP_LADDR_HI_IDX, 8'h00, 2'h0);
		wr(`EBP_LDATA_IDX, 8'ha5, 2'h0);
		chk_rd(win, 8'h00);
		wr(programming_control_reg, 8'h02, 2'h0);
		wr(programming_control_reg, 8'h00, 2'h0);
		repeat (pulse + 4) @(posedge clock);
		wr(programming_control_reg, 8'h03, 2'h0);
		chk_rd(win, 8'ha5);
		prog_byte(`EBP_OPT_IDX, 8'h08);
		chk_rd(win, 8'h00);
		chk_rd(`EBP_OPT_IDX, 8'h08);
		chk_rd(`EBP_STATUS_IDX, 8'h20);
		prog_byte(`EBP_OPT_IDX, 8'h00);
		chk_rd(`EBP_STATUS_IDX, 8'h20);
		wr(`EBP_RAM_IDX_LO, 8'h5a, 2'h0);
		wr(`EBP_RAM_IDX_HI, 8'hc3, 2'h0);
		chk_rd(`EBP_RAM_IDX_LO, 8'h5a);
		chk_rd(`EBP_RAM_IDX_HI, 8'hc3);
		rdreg(12'h040, rd, resp);
		`CHK("unmapped", 2'h2, resp)
		wr(`EBP_STATUS_IDX, 8'hff, 2'h2);
		do_reset(1'b1);
		while (clr !== 1'b1) @(posedge clock);
		`CHK("boot_mode", 1'b1, boot)
		`CHK("vector", 12'hff6, vec)
		n = 0;
		seen = 1'b0;
		while (clr === 1'b1) begin
			@(posedge clock);
			n++;
			if (stp !== 1'b0) seen = 1'b1;
		end
		`CHK("clear_width", 100, n)
		`CHK("step_in_clear", 1'b0, seen)
		`CHK("count_cleared", 12'h000, u_src.count)
		while (stp !== 1'b1) @(posedge clock);
		n = 0;
		while (stp === 1'b1) begin
			@(posedge clock);
			n++;
		end
		`CHK("step_width", 100, n)
		`CHK("count_one", 12'h001, u_src.count)
		chk_rd(`EBP_STATUS_IDX, 8'h23);
		while (u_src.count !== 12'h07f) @(posedge clock);
		count_low(lo7f);
		while (stp !== 1'b0) @(posedge clock);
		count_low(lo80);
		`CHK("eprom_dwell", 1'b1, lo80 > lo7f)
		`CHK("programmed_early", 1'b0, led_p)
		`CHK("verified_early", 1'b0, led_v)
		tally_and_finish();
	end
endmodule : ebp_top_tb_top
`default_nettype wire
